/* design/adchst_pkg.sv */
// Package of constants for the host controller of a parallel ADC.
// Assumes a 50 MHz system clock; all pin timing is counted in its cycles.
//
// Overview of operation
// [R01] Mode pin low read mode, high write-read
// [R02] Channel code binary, top eight-input code reference
// [R03] Host holds address acquisition time before start
// [R04] Read mode: chip select and read low start
// [R05] Read mode: hold read until result appears
// [R06] Ready output is open collector, no pull-up
// [R07] Ready low after select, high at finish
// [R08] End flag low at finish, high on strobe
// [R09] Write-read: write falling edge starts conversion
// [R10] Write rising edge latches upper four bits
// [R11] Lower bits latched, end flag low, readable
// [R12] Wait acquisition time after flag before write
// [R13] Internal delay: wait flag, then read byte
// [R14] Read before flag for fastest conversion
// [R15] Early read makes flag low, strobe clears
// [R16] Tied strobes start new, output previous result
// [R17] Reference switch: wait power-up plus turn-on
// [R18] Strobes ignored unless chip select low
// [R19] Power-down low shuts, wait 900ns after wake
// [R20] Mode pin defaults low when unconnected
// [R21] Data outputs driven only during select and read
// [R22] Discard first conversion after power-up; code discards only first after reset, not after wake
package adchst_pkg;

  // ----------------------------------------------------------------------
  // Clock and pin timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ        = 50;   // System clock rate
  localparam int T_ACQ_NS       = 450;  // Acquisition time
  localparam int T_WR_NS        = 600;  // Write pulse width
  localparam int T_RD_DLY_NS    = 800;  // Write rise to early read
  localparam int T_CONV_NS      = 1800; // Total fastest conversion
  localparam int T_WAKE_NS      = 900;  // Wake-up plus acquisition
  localparam int T_SWITCH_NS    = 200;  // Reference switch turn-on
  localparam int T_RD_HOLD_NS   = 200;  // Read pulse after data valid
  localparam int T_TIMEOUT_NS   = 4000; // Give-up time on flag wait

  // Least times round up
  localparam int CYC_ACQ     = (T_ACQ_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_WR      = (T_WR_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_RD_DLY  = (T_RD_DLY_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_WAKE    =
    ((T_WAKE_NS + T_SWITCH_NS) * CLK_MHZ + 999) / 1000;
  localparam int CYC_RD_HOLD = (T_RD_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_CONV    = (T_CONV_NS * CLK_MHZ + 999) / 1000;
  // Longest time rounds down
  localparam int CYC_TIMEOUT = (T_TIMEOUT_NS * CLK_MHZ) / 1000;

  localparam int CNT_W = 8;             // Wait counter width

  // ----------------------------------------------------------------------
  // Register map of the controller
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL   = 4'h0; // Control, write to start
  localparam logic [3:0] ADDR_STATUS = 4'h1; // Busy, valid, timeout
  localparam logic [3:0] ADDR_DATA   = 4'h2; // Last result
  localparam logic [3:0] ADDR_POWER  = 4'h3; // Power-down control

  // Control fields
  localparam int CTRL_CH_LSB   = 0;     // Channel code bits 2:0
  localparam int CTRL_MODE_BIT = 3;     // 0 read mode, 1 write-read
  localparam int CTRL_OPT_LSB  = 4;     // Write-read option bits 5:4
  localparam int CTRL_GO_BIT   = 7;     // Start a conversion

  // Status fields
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_VALID_BIT = 1;
  localparam int ST_TOUT_BIT  = 2;
  localparam int ST_PRIME_BIT = 3;      // First conversion done

  typedef enum logic [1:0] {
    ADCHST_OPT_INTL = 2'h0,             // Wait for end flag
    ADCHST_OPT_EARLY = 2'h1,            // Read before delay
    ADCHST_OPT_PIPE = 2'h2              // Tied strobes
  } adchst_opt_t;

  typedef enum logic [2:0] {
    ADCHST_IDLE  = 3'h0,
    ADCHST_ACQ   = 3'h1,
    ADCHST_WRLOW = 3'h2,
    ADCHST_DELAY = 3'h3,
    ADCHST_FLAG  = 3'h4,
    ADCHST_RDLOW = 3'h5,
    ADCHST_WAKE  = 3'h6
  } adchst_state_t;

endpackage

/* design/adchst_sync.sv */
// Two flip-flop synchroniser for one pin level.
// Assumes the pin is asynchronous to clk_sys.
`timescale 1ns/1ps
module adchst_sync #(
  parameter logic RST_VAL = 1'b1        // Level held during reset
) (
  input  wire logic clk_sys,            // System clock
  input  wire logic rstn,               // Async reset, active low
  input  wire logic pin_in,             // Raw pin level
  output logic      sync_out            // Synchronised level
);

  logic meta_q;                         // First stage, read only below

  // ----------------------------------------------------------------------
  // Two stages
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meta_q   <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_q   <= pin_in;
      sync_out <= meta_q;
    end
  end

endmodule

/* design/adchst_top.sv */
// Host controller driving a self-timed 8-bit multichannel ADC by pins.
// Assumes software on a plain strobe port; ADC pins asynchronous.
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module adchst_top (
  input  wire logic       clk_sys,       // System clock 50 MHz
  input  wire logic       rstn,          // Async reset, active low
  input  wire logic [3:0] addr,          // Register address
  input  wire logic [7:0] wdata,         // Write data
  input  wire logic       wr_stb,        // Write strobe
  input  wire logic       rd_stb,        // Read strobe
  output logic      [7:0] rdata,         // Read data, next cycle
  output logic            cs_n,          // Chip select to ADC
  output logic            rd_n,          // Read strobe to ADC
  output logic            wr_o,          // Write level on shared pin
  output logic            wr_oe,         // Shared pin drive enable
  input  wire logic       rdy_i,         // Shared pin level (ready)
  input  wire logic       int_n,         // End-of-conversion flag
  output logic            mode_o,        // Interface-mode pin
  output logic            power_down_n,  // Power-down pin
  output logic            channel_sel_bit0, // Channel address LSB
  output logic            channel_sel_bit1, // Channel address
  output logic            channel_sel_bit2, // Channel address MSB
  input  wire logic [7:0] result_bus,    // ADC data lines
  output logic            busy           // Conversion or wake-up wait in progress
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    adchst_pkg::adchst_state_t st;       // Sequencer state
    logic [adchst_pkg::CNT_W-1:0] cnt;   // Wait counter
    logic [2:0] ch;                      // Channel code
    logic       mode;                    // Interface mode
    logic [1:0] opt;                     // Write-read option
    logic       pwr;                     // Power-down pin level
    logic       cs_n;
    logic       rd_n;
    logic       wr;
    logic       wr_oe;
    logic [7:0] data;                    // Captured result
    logic       valid;                   // Result ready for software
    logic       tout;                    // Flag wait timed out
    logic       prime;                   // First conversion discarded
    logic [7:0] rdata;
    logic       busy;                    // Sequencer not idle
  } adchst_reg_t;

  adchst_reg_t s_q;                      // Registered state
  adchst_reg_t s_d;                      // Next state
  logic        int_s;                    // Synchronised end flag
  logic        rdy_s;                    // Synchronised ready
  logic [7:0]  res_s;                    // Synchronised data lines

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  adchst_sync #(.RST_VAL(1'b1)) u_sync_int (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .pin_in   (int_n),
    .sync_out (int_s)
  );
  adchst_sync #(.RST_VAL(1'b1)) u_sync_rdy (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .pin_in   (rdy_i),
    .sync_out (rdy_s)
  );
  for (genvar i = 0; i < 8; i++) begin : g_res
    adchst_sync #(.RST_VAL(1'b0)) u_sync_res (
      .clk_sys  (clk_sys),
      .rstn     (rstn),
      .pin_in   (result_bus[i]),
      .sync_out (res_s[i])
    );
  end

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    logic go;
    go  = 1'b0;
    s_d = s_q;
    s_d.rdata = 8'h00;
    // Register reads
    if (rd_stb) begin
      unique case (addr)
        adchst_pkg::ADDR_CTRL:
          s_d.rdata = {1'b0, 1'b0, s_q.opt, s_q.mode, s_q.ch};
        adchst_pkg::ADDR_STATUS: begin
          s_d.rdata[adchst_pkg::ST_BUSY_BIT]  =
            (s_q.st != adchst_pkg::ADCHST_IDLE);
          s_d.rdata[adchst_pkg::ST_VALID_BIT] = s_q.valid;
          s_d.rdata[adchst_pkg::ST_TOUT_BIT]  = s_q.tout;
          s_d.rdata[adchst_pkg::ST_PRIME_BIT] = s_q.prime;
        end
        adchst_pkg::ADDR_DATA:  s_d.rdata = s_q.data;
        adchst_pkg::ADDR_POWER: s_d.rdata = {7'h00, s_q.pwr};
        default:                s_d.rdata = 8'h00;
      endcase
      // Reading the result consumes it; a new capture this cycle wins
      if (addr == adchst_pkg::ADDR_DATA) begin
        s_d.valid = 1'b0;
      end
    end
    // Register writes, accepted only while idle
    if (wr_stb && s_q.st == adchst_pkg::ADCHST_IDLE) begin
      if (addr == adchst_pkg::ADDR_CTRL) begin
        s_d.ch   = wdata[adchst_pkg::CTRL_CH_LSB +: 3];      // R02
        s_d.mode = wdata[adchst_pkg::CTRL_MODE_BIT];         // R01
        s_d.opt  = wdata[adchst_pkg::CTRL_OPT_LSB +: 2];
        go       = wdata[adchst_pkg::CTRL_GO_BIT];
        s_d.tout = 1'b0;
      end else if (addr == adchst_pkg::ADDR_POWER) begin
        s_d.pwr = wdata[0];                                  // R19
        if (wdata[0] && !s_q.pwr) begin
          // Wake: wait power-up plus switch turn-on
          s_d.st  = adchst_pkg::ADCHST_WAKE;                 // R17
          s_d.cnt = adchst_pkg::CNT_W'(adchst_pkg::CYC_WAKE);
        end
      end
    end
    if (s_q.cnt != '0) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
    // Sequencer
    unique case (s_q.st)
      adchst_pkg::ADCHST_IDLE: begin
        if (go && s_q.pwr) begin
          // Address held for acquisition time before start
          s_d.st  = adchst_pkg::ADCHST_ACQ;                  // R03
          s_d.cnt = adchst_pkg::CNT_W'(adchst_pkg::CYC_ACQ); // R12
        end
      end
      adchst_pkg::ADCHST_WAKE: begin
        if (s_q.cnt == '0) begin
          s_d.st = adchst_pkg::ADCHST_IDLE;                  // R19
        end
      end
      adchst_pkg::ADCHST_ACQ: begin
        if (s_q.cnt == '0) begin
          s_d.cs_n = 1'b0;                                   // R18
          if (!s_q.mode) begin
            // Read mode: select and read low together
            s_d.rd_n = 1'b0;                                 // R04
            s_d.st   = adchst_pkg::ADCHST_FLAG;
            s_d.cnt  = adchst_pkg::CNT_W'(adchst_pkg::CYC_TIMEOUT);
          end else begin
            s_d.wr  = 1'b0;                                  // R09
            if (s_q.opt == adchst_pkg::ADCHST_OPT_PIPE) begin
              s_d.rd_n = 1'b0;                               // R16
            end
            s_d.st  = adchst_pkg::ADCHST_WRLOW;
            s_d.cnt = adchst_pkg::CNT_W'(adchst_pkg::CYC_WR);
          end
        end
      end
      adchst_pkg::ADCHST_WRLOW: begin
        if (s_q.cnt == '0) begin
          s_d.wr = 1'b1;                                     // R10
          if (s_q.opt == adchst_pkg::ADCHST_OPT_PIPE) begin
            // Previous result stands on the bus now
            s_d.data  = res_s;                               // R16
            s_d.valid = s_q.prime;                           // R22
            s_d.prime = 1'b1;
            s_d.rd_n  = 1'b1;
            s_d.cs_n  = 1'b1;
            s_d.st    = adchst_pkg::ADCHST_IDLE;
          end else if (s_q.opt == adchst_pkg::ADCHST_OPT_EARLY) begin
            s_d.st  = adchst_pkg::ADCHST_DELAY;
            s_d.cnt = adchst_pkg::CNT_W'(adchst_pkg::CYC_RD_DLY);
          end else begin
            s_d.st  = adchst_pkg::ADCHST_FLAG;               // R13
            s_d.cnt = adchst_pkg::CNT_W'(adchst_pkg::CYC_TIMEOUT);
          end
        end
      end
      adchst_pkg::ADCHST_DELAY: begin
        if (s_q.cnt == '0) begin
          // Read before the flag falls
          s_d.rd_n = 1'b0;                                   // R14
          s_d.st   = adchst_pkg::ADCHST_FLAG;                // R15
          s_d.cnt  = adchst_pkg::CNT_W'(adchst_pkg::CYC_TIMEOUT);
        end
      end
      adchst_pkg::ADCHST_FLAG: begin
        // Wait for end flag; in read mode ready must be high too
        if (!int_s && (s_q.mode || rdy_s)) begin             // R05 R07
          s_d.rd_n = 1'b0;                                   // R13
          s_d.st   = adchst_pkg::ADCHST_RDLOW;               // R11
          s_d.cnt  = adchst_pkg::CNT_W'(adchst_pkg::CYC_RD_HOLD);
        end else if (s_q.cnt == '0) begin
          s_d.tout = 1'b1;
          s_d.rd_n = 1'b1;
          s_d.cs_n = 1'b1;
          s_d.st   = adchst_pkg::ADCHST_IDLE;
        end
      end
      adchst_pkg::ADCHST_RDLOW: begin
        if (s_q.cnt == '0) begin
          s_d.data  = res_s;                                 // R21
          s_d.valid = s_q.prime;                             // R22
          s_d.prime = 1'b1;
          // Rising read strobe clears the end flag
          s_d.rd_n  = 1'b1;                                  // R08
          s_d.cs_n  = 1'b1;
          s_d.st    = adchst_pkg::ADCHST_IDLE;
        end
      end
      default: s_d.st = adchst_pkg::ADCHST_IDLE;
    endcase
    // Shared pin driven only in write-read mode; open collector otherwise
    s_d.wr_oe = s_d.mode;                                    // R06
    if (!s_d.pwr) begin
      s_d.prime = s_q.prime;
    end
    // Busy registered so the pin comes straight from a flip-flop
    s_d.busy = (s_d.st != adchst_pkg::ADCHST_IDLE);
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_q       <= '0;
      s_q.st    <= adchst_pkg::ADCHST_IDLE;
      s_q.pwr   <= 1'b1;
      s_q.cs_n  <= 1'b1;
      s_q.rd_n  <= 1'b1;
      s_q.wr    <= 1'b1;
      s_q.mode  <= 1'b0;                                     // R20
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs straight from the state register
  // ----------------------------------------------------------------------
  assign rdata            = s_q.rdata;
  assign cs_n             = s_q.cs_n;
  assign rd_n             = s_q.rd_n;
  assign wr_o             = s_q.wr;
  assign wr_oe            = s_q.wr_oe;
  assign mode_o           = s_q.mode;
  assign power_down_n     = s_q.pwr;
  assign channel_sel_bit0 = s_q.ch[0];
  assign channel_sel_bit1 = s_q.ch[1];
  assign channel_sel_bit2 = s_q.ch[2];
  assign busy             = s_q.busy;

endmodule

/* verification/adchst_monitor.sv */
// Checker of the ADC host controller pin timing.
// Bound to adchst_top; sees only its ports, one clock domain.
`timescale 1ns/1ps
module adchst_monitor (
  input  wire logic clk_sys,          // System clock
  input  wire logic rstn,             // Async reset, active low
  input  wire logic cs_n,             // Chip select
  input  wire logic rd_n,             // Read strobe
  input  wire logic wr_o,             // Write level
  input  wire logic wr_oe,            // Shared pin enable
  input  wire logic int_n,            // End flag
  input  wire logic mode_o,           // Mode pin
  input  wire logic power_down_n,     // Power-down pin
  input  wire logic channel_sel_bit0, // Channel LSB
  input  wire logic channel_sel_bit1, // Channel bit
  input  wire logic channel_sel_bit2  // Channel MSB
);
  // ---------------------------------------------------------------
  // Helper logic
  // ---------------------------------------------------------------
  logic [2:0] ch;                     // Channel code
  logic [7:0] wake_q;                 // Cycles since wake, saturating
  assign ch = {channel_sel_bit2, channel_sel_bit1, channel_sel_bit0};
  // Counts from power-down release; reset counts as long awake
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) wake_q <= 8'hFF;
    else if (!power_down_n) wake_q <= 8'h00;
    else if (wake_q != 8'hFF) wake_q <= wake_q + 8'h01;
  end
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_rd_needs_cs: assert property (!rd_n |-> !cs_n)
    else $error("read strobe without chip select");
  a_rdmode_nodrive: assert property (!cs_n && !mode_o |-> !wr_oe)
    else $error("shared pin driven in read mode");
  a_mode_held: assert property (
    !cs_n && !$past(cs_n) |-> $stable(mode_o))
    else $error("mode pin moved during access");
  a_chan_acq: assert property ($fell(cs_n) |-> ch == $past(ch, 22))
    else $error("channel changed inside acquisition");
  a_chan_held: assert property (!cs_n |-> $stable(ch))
    else $error("channel changed during access");
  a_wr_pulse: assert property ($fell(wr_o) |-> ##30 !wr_o ##1 wr_o)
    else $error("write pulse not 31 cycles");
  a_rd_span: assert property ($rose(rd_n) |-> !$past(rd_n, 8))
    else $error("read pulse too short");
  a_release_pair: assert property ($rose(rd_n) |-> $rose(cs_n))
    else $error("read and select not released together");
  a_flag_first: assert property (
    $rose(rd_n) && !mode_o |-> !$past(int_n, 4))
    else $error("read ended before end flag");
  a_pd_quiet: assert property (!power_down_n |-> cs_n)
    else $error("access while powered down");
  a_wake_wait: assert property ($fell(cs_n) |-> wake_q >= 8'h2D)
    else $error("access too soon after wake");
endmodule

/* verification/adchst_adc_model.sv */
// Behavioural model of the self-timed 8-bit ADC at the pins.
// Assumes the bench resolves the shared write/ready pin with a pull-up.
`timescale 1ns/1ps
module adchst_adc_model #(
  parameter realtime T_CONV = 1600.0, // Read mode conversion, ns
  parameter realtime T_INTL = 1200.0, // Internal delay, ns
  parameter realtime T_RI   = 300.0,  // Read low to flag, ns
  parameter realtime T_ACQ  = 450.0,  // Acquisition time, ns
  parameter realtime T_WAKE = 900.0   // Wake and acquire, ns
) (
  input  wire logic       cs_n,       // Chip select
  input  wire logic       rd_n,       // Read strobe
  input  wire logic       wr_lvl,     // Shared pin level
  input  wire logic       mode,       // Mode pin
  input  wire logic       pd_n,       // Power-down pin
  input  wire logic [2:0] ch,         // Channel address
  output logic            int_n = 1'h1,   // End flag
  output logic            rdy_low = 1'h0, // Pulls ready low
  output logic      [7:0] result_bus = 8'h00, // Data lines
  output int              viol = 0        // Host timing faults
);
  logic    [7:0] out_q = 8'h00;       // Output latch
  logic    [7:0] val;                 // Result being converted
  logic          conv_q = 1'h0;       // Write-read conversion running
  realtime       t_int = -1.0e6;      // Last flag fall
  realtime       t_ch = -1.0e6;       // Last address change
  realtime       t_wake = -1.0e6;     // Last wake
  // Start of a conversion: check host spacing, sample the input
  task automatic start();
    if ($realtime - t_int < T_ACQ || $realtime - t_ch < T_ACQ ||
        $realtime - t_wake < T_WAKE) viol++;
    val = {~ch, 5'h13};
  endtask
  always @(ch) t_ch = $realtime;
  always @(posedge pd_n) t_wake = $realtime;
  always @(negedge cs_n) if (!mode) rdy_low = 1'h1;
  // Read mode conversion
  always @(cs_n or rd_n)
    if (!cs_n && !rd_n && !mode && pd_n) begin
      start();
      #(T_CONV);
      out_q = val;
      int_n = 1'h0;
      rdy_low = 1'h0;
      t_int = $realtime;
      wait (cs_n || rd_n);
    end
  always @(posedge cs_n or posedge rd_n) int_n = 1'h1;
  // Write-read mode: write falls to start, rises to latch upper half
  // Pin levels that move in the same instant settle before the test
  always @(negedge wr_lvl) begin
    #1ps;
    if (!cs_n && mode && pd_n) begin
      start();
      conv_q = 1'h1;
    end
  end
  always @(posedge wr_lvl) begin
    #1ps;
    if (!cs_n && mode && conv_q) begin
      out_q = {val[7:4], ~out_q[3:0]};
      fork
        #(T_INTL);
        @(negedge rd_n) #(T_RI);
      join_any
      disable fork;
      out_q[3:0] = val[3:0];
      int_n = 1'h0;
      t_int = $realtime;
      conv_q = 1'h0;
    end
  end
  // Data lines driven only in a read; else inverted at each change of cs_n, rd_n or out_q
  always @(cs_n or rd_n or out_q)
    if (!cs_n && !rd_n) result_bus = out_q;
    else result_bus = ~result_bus;
endmodule

/* verification/adchst_tb_top.sv */
// Self-checking bench of the ADC host controller with an ADC model.
// Assumes the monitor and model files compile before this one.
`timescale 1ns/1ps
module adchst_tb_top;
  logic       clk_sys, rstn, wr_stb, rd_stb; // Clock, reset, strobes
  logic [3:0] addr;                          // Register address
  logic [7:0] wdata, rdata, last_val;        // Bus data, last result
  wire        cs_n, rd_n, wr_o, wr_oe, int_n, mode_o, power_down_n;
  wire  [2:0] ch;                            // Channel pins
  wire  [7:0] result_bus;                    // ADC data lines
  wire        busy, rdy_low, shared_pin;     // Status, pin levels
  int         viol, fail_count, n_compared;  // Counters
  int         seed = 32'h42b5ed40;           // Random seed
  logic [7:0] exp_q[$];                      // Expected read data
  logic       pend_q = 1'h0;                 // Read answer due
  // Shared pin: host drive, else open collector with pull-up
  assign shared_pin = wr_oe ? wr_o : !rdy_low;
  initial begin
    clk_sys = 1'h0;
    forever #10 clk_sys = ~clk_sys;
  end
  adchst_top u_dut (.clk_sys, .rstn, .addr, .wdata, .wr_stb, .rd_stb,
    .rdata, .cs_n, .rd_n, .wr_o, .wr_oe, .rdy_i(shared_pin), .int_n,
    .mode_o, .power_down_n, .channel_sel_bit0(ch[0]),
    .channel_sel_bit1(ch[1]), .channel_sel_bit2(ch[2]), .result_bus, .busy);
  adchst_adc_model u_adc (.cs_n, .rd_n, .wr_lvl(shared_pin), .mode(mode_o),
    .pd_n(power_down_n), .ch, .int_n, .rdy_low, .result_bus, .viol);
  // ---------------------------------------------------------------
  // Checking and bus tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_compared++;
    if (seen !== want) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'h1;
    @(posedge clk_sys);
    wr_stb <= 1'h0;
  endtask
  task automatic reg_rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk_sys);
    addr <= a;
    rd_stb <= 1'h1;
    @(posedge clk_sys);
    rd_stb <= 1'h0;
  endtask
  // Watcher: read data stands the cycle after the strobe
  always @(posedge clk_sys) begin
    if (pend_q) check(rdata, exp_q.pop_front());
    pend_q <= rd_stb;
  end
  task automatic wait_idle();
    int n = 0;
    repeat (3) @(posedge clk_sys);
    while (busy !== 1'h0) begin
      n++;
      if (n > 2000) begin
        fail_count++;
        final_report();
      end
      @(posedge clk_sys);
    end
  endtask
  // One conversion: start, wait, check pins, status and, unless first, data
  task automatic convert(input logic m, input logic [1:0] opt,
                         input logic [2:0] c, input logic first);
    logic [7:0] want;
    want = (m && opt == 2'h2) ? last_val : {~c, 5'h13};
    reg_wr(adchst_pkg::ADDR_CTRL, {2'h2, opt, m, c});
    wait_idle();
    check({5'h00, ch}, {5'h00, c});
    check({7'h00, mode_o}, {7'h00, m});
    reg_rd(adchst_pkg::ADDR_STATUS, first ? 8'h08 : 8'h0A);
    if (!first) reg_rd(adchst_pkg::ADDR_DATA, want);
    last_val = {~c, 5'h13};
    if (m && opt == 2'h2) repeat (80) @(posedge clk_sys);
    check(8'(viol), 8'h00);
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    int k;
    rstn = 1'h0;
    addr = 4'h0;
    wdata = 8'h00;
    wr_stb = 1'h0;
    rd_stb = 1'h0;
    repeat (20) @(posedge clk_sys);
    rstn <= 1'h1;
    check({7'h00, mode_o}, 8'h00);
    reg_rd(adchst_pkg::ADDR_POWER, 8'h01);
    reg_rd(adchst_pkg::ADDR_STATUS, 8'h00);
    reg_rd(4'hF, 8'h00);
    $display("register test done");
    for (int i = 0; i < 9; i++) begin
      k = i % 4;
      convert(k != 0, (k == 0) ? 2'h0 : 2'(k - 1), 3'($random(seed)), i == 0);
      $display("conversion %0d done", i);
    end
    reg_wr(adchst_pkg::ADDR_POWER, 8'h00);
    reg_wr(adchst_pkg::ADDR_CTRL, 8'h80);
    repeat (5) @(posedge clk_sys);
    check({7'h00, power_down_n}, 8'h00);
    check({7'h00, busy}, 8'h00);
    reg_wr(adchst_pkg::ADDR_POWER, 8'h01);
    wait_idle();
    convert(1'h0, 2'h0, 3'h7, 1'h0);
    $display("power-down test done");
    // Let the watcher compare the last read answer
    repeat (2) @(posedge clk_sys);
    final_report();
  end
endmodule
bind adchst_top adchst_monitor u_mon (.clk_sys, .rstn, .cs_n, .rd_n,
  .wr_o, .wr_oe, .int_n, .mode_o, .power_down_n, .channel_sel_bit0,
  .channel_sel_bit1, .channel_sel_bit2);
